/* bench/nic_command_decoder_bench.sv */
// Self-checking bench of the command decoder with the engine responder.
// Assumes AXI4-Lite timing as handed over; pulses are caught in sticky flags.
`timescale 1ns/100ps
module nic_command_decoder_bench;
	logic                CLK_SYS = 0, ARST_N = 0, clr = 0;
	logic [7:0]          AWADDR = '0, ARADDR = '0;
	logic [31:0]         WDATA = '0, RDATA, s;
	logic [3:0]          WSTRB = 4'h3;
	logic                AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0, MC_CHECK = 0;
	logic                TX_PKT_ACTIVE = 0, ADAPTER_OPEN = 0, TX_PKT_PRESENT = 0, TX_PKT_LOADED = 0;
	logic [13:0]         TX_FIFO_BYTES = '0;
	logic [5:0]          MC_CRC = '0;
	logic [1:0]          BRESP, RRESP, r;
	logic                AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_LIST_IDLE, RX_LIST_IDLE, DROP_DONE;
	logic                PHY_SLEEP, TX_ENGINE_ON, TX_LIST_HOLD, RX_LIST_HOLD, DROP_FRAME, TX_QUEUE;
	logic                MC_ACCEPT, MC_DISCARD, CMD_BUSY;
	nicd_pkg::nicd_rst_t RST_PULSE;
	logic [11:0]         seen = '0;
	int                  phy_n = 0, n_mismatch = 0, compares = 0;
	nicd_command_decoder dut (.*);
	nicd_engine_model    eng (.*);
	initial forever #2.5 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) seen <= clr ? '0 : seen | {DROP_FRAME, MC_DISCARD, MC_ACCEPT, RST_PULSE};
	always @(posedge CLK_SYS) phy_n <= clr ? 0 : phy_n + int'(PHY_SLEEP);
	// ==========================================================
	// Bus and compare helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		n_mismatch += int'(got !== exp);
		if (got !== exp) $display("mismatch at %0t: got %h expected %h", $time, got, exp);
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK_SYS);
		AWADDR <= a; WDATA <= {16'h0, d}; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
		do
		begin
			@(posedge CLK_SYS);
			if (AWREADY) AWVALID <= 0;
			if (WREADY) WVALID <= 0;
		end while (BVALID !== 1'b1);
		r = BRESP;
		BREADY <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge CLK_SYS);
		ARADDR <= a; ARVALID <= 1; RREADY <= 1;
		do
		begin
			@(posedge CLK_SYS);
			if (ARREADY) ARVALID <= 0;
		end while (RVALID !== 1'b1);
		s = RDATA; r = RRESP; RREADY <= 0;
	endtask : rd
	task automatic rv(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(s, e);
	endtask : rv
	task automatic idle;
		do rd(nicd_pkg::ADDR_STAT); while (s[nicd_pkg::STAT_BUSY] !== 1'b0);
	endtask : idle
	// Don't-care bits always written as zero
	task automatic cmd(input logic [15:0] d);
		@(posedge CLK_SYS) clr <= 1;
		@(posedge CLK_SYS) clr <= 0;
		wr(nicd_pkg::ADDR_CMD, d);
		idle;
	endtask : cmd
	task automatic q(input logic o, input logic [13:0] n, input logic l, input logic e);
		ADAPTER_OPEN <= o; TX_FIFO_BYTES <= n; TX_PKT_LOADED <= l;
		repeat (3) @(posedge CLK_SYS);
		chk(TX_QUEUE, e);
	endtask : q
	task automatic mc(input logic [5:0] c);
		MC_CRC <= c; MC_CHECK <= 1;
		@(posedge CLK_SYS) MC_CHECK <= 0;
		repeat (2) @(posedge CLK_SYS);
	endtask : mc
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rv(nicd_pkg::ADDR_STAT, 0);
		rv(nicd_pkg::ADDR_LEVEL, 32'h1ffc);
		rd(8'h20);
		chk(r, nicd_pkg::RESP_SLVERR);
		wr(8'h20, 16'h0000);
		chk(r, nicd_pkg::RESP_SLVERR);
	endtask : t_reset
	task automatic t_full;
		int b[4] = '{2, 3, 5, 8};
		for (int i = 0; i < 4; i++)
		begin
			cmd(16'h012d & ~(16'h1 << b[i]));
			chk(seen[8:4], 5'h08 >> i);
			chk(phy_n, 0);
		end
		cmd(16'h0000);
		chk(seen[8], 1);
		chk(phy_n, 22);
	endtask : t_full
	task automatic t_paths;
		cmd(16'h9923);
		rv(nicd_pkg::ADDR_LEVEL, 32'h048c);
		cmd(16'h5900);
		rv(nicd_pkg::ADDR_LEVEL, 32'h1ffc);
		chk(seen[3:2], 2'h2);
		cmd(16'h5808);
		chk(seen[3:2], 2'h1);
		cmd(16'h2900);
		chk(seen[1:0], 2'h2);
	endtask : t_paths
	task automatic t_lists;
		wr(nicd_pkg::ADDR_CMD, 16'h3002);
		rv(nicd_pkg::ADDR_STAT, 32'h5);
		idle;
		rv(nicd_pkg::ADDR_STAT, 32'h4);
		cmd(16'h3003);
		rv(nicd_pkg::ADDR_STAT, 0);
		cmd(16'h3000);
		rv(nicd_pkg::ADDR_STAT, 32'h8);
		cmd(16'h2808);
		rv(nicd_pkg::ADDR_STAT, 0);
		chk(seen[1:0], 2'h1);
		wr(nicd_pkg::ADDR_CMD, 16'hc000);
		rv(nicd_pkg::ADDR_STAT, 32'h1);
		idle;
		chk(seen[11], 1);
		wr(nicd_pkg::ADDR_CMD, 16'h3800);
		rv(nicd_pkg::ADDR_STAT, 0);
	endtask : t_lists
	task automatic t_tx;
		TX_PKT_ACTIVE <= 1;
		cmd(16'h4800);
		rv(nicd_pkg::ADDR_STAT, 32'h2);
		wr(nicd_pkg::ADDR_CMD, 16'h5000);
		rv(nicd_pkg::ADDR_STAT, 32'h3);
		chk({CMD_BUSY, TX_ENGINE_ON}, 2'h3);
		TX_PKT_ACTIVE <= 0;
		idle;
		rv(nicd_pkg::ADDR_STAT, 0);
		cmd(16'h4800);
		cmd(16'h9804);
		TX_PKT_PRESENT <= 1;
		q(1, 14'h10, 0, 0);
		q(1, 14'h11, 0, 1);
		q(0, 14'h11, 0, 0);
		q(1, 14'h05, 1, 1);
		cmd(16'h5000);
		q(1, 14'h11, 0, 0);
	endtask : t_tx
	task automatic t_hash;
		cmd(16'hcc05);
		rv(nicd_pkg::ADDR_HASH_LO, 32'h20);
		mc(6'h05);
		chk(seen[10:9], 2'h1);
		cmd(16'hc805);
		mc(6'h05);
		chk(seen[10:9], 2'h2);
		cmd(16'hcc3f);
		rv(nicd_pkg::ADDR_HASH_HI, 32'h80000000);
	endtask : t_hash
	task automatic test_done;
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (3) @(posedge CLK_SYS);
		ARST_N <= 1;
		t_reset; t_full; t_paths; t_lists; t_tx; t_hash;
		test_done;
	end
	initial
	begin
		#40000;
		n_mismatch++;
		test_done;
	end
endmodule : nic_command_decoder_bench

/* bench/nicd_engine_model.sv */
// Engine-side responder for the command decoder.
// Assumes hold and drop controls arrive on CLK_SYS; answers after DLY cycles.
`timescale 1ns/100ps
module nicd_engine_model #(
	parameter int DLY = 20
) (
	input  wire logic CLK_SYS,
	input  wire logic ARST_N,
	input  wire logic TX_LIST_HOLD,
	input  wire logic RX_LIST_HOLD,
	input  wire logic DROP_FRAME,
	output logic      TX_LIST_IDLE,
	output logic      RX_LIST_IDLE,
	output logic      DROP_DONE
);
	// ==========================================================
	// Slow completion so the decoder has to keep busy up
	int         cnt_q;
	logic       drop_q;
	logic [1:0] hold_q;
	always_ff @(posedge CLK_SYS or negedge ARST_N)
		if (!ARST_N)
			hold_q <= 2'h0;
		else
			hold_q <= {TX_LIST_HOLD, RX_LIST_HOLD};
	always_ff @(posedge CLK_SYS or negedge ARST_N)
		if (!ARST_N)
			cnt_q <= 0;
		else if (DROP_FRAME || hold_q != {TX_LIST_HOLD, RX_LIST_HOLD})
			cnt_q <= DLY;
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
	always_ff @(posedge CLK_SYS or negedge ARST_N)
		if (!ARST_N)
			drop_q <= 1'b0;
		else if (DROP_FRAME)
			drop_q <= 1'b1;
		else if (cnt_q == 0)
			drop_q <= 1'b0;
	// Not idle until the hold change is seen, else busy would end at once
	assign TX_LIST_IDLE = cnt_q == 0 && hold_q == {TX_LIST_HOLD, RX_LIST_HOLD};
	assign RX_LIST_IDLE = cnt_q == 0 && hold_q == {TX_LIST_HOLD, RX_LIST_HOLD};
	assign DROP_DONE    = drop_q && cnt_q == 0;
endmodule : nicd_engine_model

/* hdl/nicd_command_decoder.sv */
// Command decoder of a ring network card: AXI4-Lite slave that takes
// 16-bit command words and drives reset, engine and filter controls.
// Assumes engine inputs are synchronous to CLK_SYS.
//
// What this block does
// (RULE1) Bits 15..11 are the command code, bits 10..0 its parameter.
// (RULE2) Host writes zeros into don't-care command bits.
// (RULE3) Full reset with bit 0 clear drives PHY sleep for 22 cycles.
// (RULE4) Full reset bit 2 clear resets MAC logic; set masks it.
// (RULE5) Full reset bit 3 clear resets FIFO control; set masks it.
// (RULE6) Full reset bit 5 clear resets bus interface and its registers.
// (RULE7) Full reset bit 8 clear resets upload and download engines.
// (RULE8) Full reset with all mask bits zero resets the whole device.
// (RULE9) Long commands hold busy until done; host waits for it.
// (RULE10) Transmit reset bit 3 clear flushes FIFO and resets start level.
// (RULE11) Transmit reset bit 8 clear resets the download logic.
// (RULE12) Receive reset bit 3 clear flushes the receive FIFO.
// (RULE13) Receive reset bit 8 clear resets upload logic and clears hold.
// (RULE14) Transmit engine off takes effect after current packet ends.
// (RULE15) Engine on lets frames queue; queuing also needs adapter open.
// (RULE16) Transmit list hold stops next-link fetch into the pointer.
// (RULE17) Host holds the list before editing it, then releases soon.
// (RULE18) Transmit list release resumes next-link fetching.
// (RULE19) Level command writes parameter to bits 12..2, clears 1..0.
// (RULE20) Queue when FIFO bytes exceed level, or packet fully loaded.
// (RULE21) Drop command discards top receive frame; host uses a ring.
// (RULE22) Hash command: bits 5..0 pick entry, bit 10 sets or clears.
// (RULE23) Multicast frames accepted when their CRC-indexed entry is set.
// (RULE24) Receive list hold stops pointer advance; busy until it holds.
// (RULE25) Unknown command codes are ignored and do not raise busy.
`timescale 1ns/100ps
module nicd_command_decoder #(
	parameter int ADDR_W  = 8,
	parameter int LEVEL_W = 13,
	parameter int HASH_N  = 64,
	parameter int BYTES_W = 14
) (
	input  wire logic               CLK_SYS,
	input  wire logic               ARST_N,
	input  wire logic [ADDR_W-1:0]  AWADDR,
	input  wire logic               AWVALID,
	output logic                    AWREADY,
	input  wire logic [31:0]        WDATA,
	input  wire logic [3:0]         WSTRB,
	input  wire logic               WVALID,
	output logic                    WREADY,
	output logic [1:0]              BRESP,
	output logic                    BVALID,
	input  wire logic               BREADY,
	input  wire logic [ADDR_W-1:0]  ARADDR,
	input  wire logic               ARVALID,
	output logic                    ARREADY,
	output logic [31:0]             RDATA,
	output logic [1:0]              RRESP,
	output logic                    RVALID,
	input  wire logic               RREADY,
	input  wire logic               TX_PKT_ACTIVE,
	input  wire logic               TX_LIST_IDLE,
	input  wire logic               RX_LIST_IDLE,
	input  wire logic               DROP_DONE,
	input  wire logic               ADAPTER_OPEN,
	input  wire logic               TX_PKT_PRESENT,
	input  wire logic               TX_PKT_LOADED,
	input  wire logic [BYTES_W-1:0] TX_FIFO_BYTES,
	input  wire logic               MC_CHECK,
	input  wire logic [5:0]         MC_CRC,
	output nicd_pkg::nicd_rst_t     RST_PULSE,
	output logic                    PHY_SLEEP,
	output logic                    TX_ENGINE_ON,
	output logic                    TX_LIST_HOLD,
	output logic                    RX_LIST_HOLD,
	output logic                    DROP_FRAME,
	output logic                    TX_QUEUE,
	output logic                    MC_ACCEPT,
	output logic                    MC_DISCARD,
	output logic                    CMD_BUSY
);

	if (LEVEL_W != 13 || HASH_N != 64 || BYTES_W <= LEVEL_W || ADDR_W < 5)
	begin : g_chk
		$error("nicd: unsupported parameter set");
	end

	// ==========================================================
	// Command decode
	function automatic nicd_pkg::nicd_cmd_t decode(input logic [15:0] w);
		logic [4:0] code;
		nicd_pkg::nicd_cmd_t k;
		code = w[nicd_pkg::CODE_MSB:nicd_pkg::CODE_LSB];
		k = nicd_pkg::CMD_NONE;
		case (code)
			nicd_pkg::C_FULL:  k = nicd_pkg::CMD_FULL;
			nicd_pkg::C_RXRST: k = nicd_pkg::CMD_RXRST;
			nicd_pkg::C_TXRST: k = nicd_pkg::CMD_TXRST;
			nicd_pkg::C_LEVEL: k = nicd_pkg::CMD_LEVEL;
			nicd_pkg::C_TXOFF: k = nicd_pkg::CMD_TXOFF;
			nicd_pkg::C_TXON:  k = nicd_pkg::CMD_TXON;
			nicd_pkg::C_DROP:  k = nicd_pkg::CMD_DROP;
			nicd_pkg::C_HASH:  k = nicd_pkg::CMD_HASH;
			nicd_pkg::C_LIST:
			begin
				case (w[4:0])
					nicd_pkg::L_RXHOLD: k = nicd_pkg::CMD_RXHOLD;
					nicd_pkg::L_RXREL:  k = nicd_pkg::CMD_RXREL;
					nicd_pkg::L_TXHOLD: k = nicd_pkg::CMD_TXHOLD;
					nicd_pkg::L_TXREL:  k = nicd_pkg::CMD_TXREL;
					default:            k = nicd_pkg::CMD_NONE;
				endcase
			end
			default: k = nicd_pkg::CMD_NONE;
		endcase
		return k;
	endfunction : decode

	// ==========================================================
	// AXI4-Lite write channel
	logic              awready_q;
	logic              wready_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [15:0]       wcmd_q;
	logic              wr_fire;
	logic              cmd_go;
	logic [10:0]       prm;
	nicd_pkg::nicd_cmd_t kind;
	nicd_pkg::nicd_state_t st_q;
	nicd_pkg::nicd_state_t st_d;

	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	// Writes while busy are acknowledged but dropped
	assign cmd_go  = wr_fire && waddr_q == ADDR_W'(nicd_pkg::ADDR_CMD) && st_q == nicd_pkg::ST_IDLE; // RULE9
	assign kind    = decode(wcmd_q); // RULE1
	assign prm     = wcmd_q[nicd_pkg::PARM_W-1:0]; // RULE1

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= nicd_pkg::RESP_OKAY;
			waddr_q   <= '0;
			wcmd_q    <= 16'h0000;
		end
		else
		begin
			if (AWVALID && awready_q)
			begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				waddr_q   <= AWADDR;
			end
			if (WVALID && wready_q)
			begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				// Byte write to the high lane alone reads low byte as zero
				wcmd_q   <= {WSTRB[1] ? WDATA[15:8] : 8'h00, WSTRB[0] ? WDATA[7:0] : 8'h00};
			end
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				case (waddr_q)
					ADDR_W'(nicd_pkg::ADDR_CMD),
					ADDR_W'(nicd_pkg::ADDR_STAT),
					ADDR_W'(nicd_pkg::ADDR_LEVEL),
					ADDR_W'(nicd_pkg::ADDR_HASH_LO),
					ADDR_W'(nicd_pkg::ADDR_HASH_HI): bresp_q <= nicd_pkg::RESP_OKAY;
					default:                         bresp_q <= nicd_pkg::RESP_SLVERR;
				endcase
			end
			if (bvalid_q && BREADY)
			begin
				bvalid_q  <= 1'b0;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Control state
	logic [5:0]         cnt_q;
	logic [5:0]         cnt_d;
	logic               busy_q;
	logic [5:0]         phy_cnt_q;
	logic               phy_q;
	logic               tx_on_q;
	logic               tx_hold_q;
	logic               rx_hold_q;
	logic               drop_q;
	logic [LEVEL_W-1:0] level_q;
	logic [HASH_N-1:0]  hash_q;
	logic               queue_q;
	logic               mc_acc_q;
	logic               mc_dis_q;
	nicd_pkg::nicd_rst_t rst_q;
	logic               is_full;
	logic               sr_all;
	logic               sr_dma;
	logic               lvl_rst;

	assign is_full = cmd_go && kind == nicd_pkg::CMD_FULL;
	assign sr_all  = is_full && prm[nicd_pkg::B_PHY] == 1'b0 && prm[nicd_pkg::B_MAC] == 1'b0
		&& prm[nicd_pkg::B_FIFO] == 1'b0 && prm[nicd_pkg::B_BUS] == 1'b0
		&& prm[nicd_pkg::B_DMA] == 1'b0; // RULE8
	assign sr_dma  = is_full && !prm[nicd_pkg::B_DMA]; // RULE7
	assign lvl_rst = (is_full || (cmd_go && kind == nicd_pkg::CMD_TXRST)) && !prm[nicd_pkg::B_FIFO]; // RULE10

	// ==========================================================
	// Busy sequencer
	always_comb
	begin
		st_d  = st_q;
		cnt_d = cnt_q;
		case (st_q)
			nicd_pkg::ST_IDLE:
			begin
				if (cmd_go)
				begin
					case (kind)
						nicd_pkg::CMD_FULL:
						begin
							st_d  = nicd_pkg::ST_HOLD;
							cnt_d = nicd_pkg::PHY_SLEEP_CYCLES - 6'h01; // RULE9
						end
						nicd_pkg::CMD_RXRST,
						nicd_pkg::CMD_TXRST:
						begin
							st_d  = nicd_pkg::ST_HOLD;
							cnt_d = nicd_pkg::PATH_RST_CYCLES - 6'h01; // RULE9
						end
						nicd_pkg::CMD_TXOFF:  st_d = nicd_pkg::ST_TXOFF; // RULE14
						nicd_pkg::CMD_TXHOLD: st_d = nicd_pkg::ST_TXLIST; // RULE16
						nicd_pkg::CMD_RXHOLD: st_d = nicd_pkg::ST_RXLIST; // RULE24
						nicd_pkg::CMD_DROP:   st_d = nicd_pkg::ST_DROP; // RULE21
						default:              st_d = nicd_pkg::ST_IDLE; // RULE25
					endcase
				end
			end
			nicd_pkg::ST_HOLD:
			begin
				if (cnt_q == 6'h00)
					st_d = nicd_pkg::ST_IDLE;
				else
					cnt_d = cnt_q - 6'h01;
			end
			nicd_pkg::ST_TXOFF:  if (!TX_PKT_ACTIVE) st_d = nicd_pkg::ST_IDLE; // RULE14
			nicd_pkg::ST_TXLIST: if (TX_LIST_IDLE) st_d = nicd_pkg::ST_IDLE; // RULE16
			nicd_pkg::ST_RXLIST: if (RX_LIST_IDLE) st_d = nicd_pkg::ST_IDLE; // RULE24
			nicd_pkg::ST_DROP:   if (DROP_DONE) st_d = nicd_pkg::ST_IDLE; // RULE21
			default:             st_d = nicd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			st_q   <= nicd_pkg::ST_IDLE;
			cnt_q  <= 6'h00;
			busy_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			busy_q <= st_d != nicd_pkg::ST_IDLE; // RULE9
		end
	end

	// ==========================================================
	// Reset pulses and PHY sleep
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			rst_q <= '0;
		else
		begin
			rst_q          <= '0;
			rst_q.device   <= sr_all; // RULE8
			rst_q.mac      <= is_full && !prm[nicd_pkg::B_MAC]; // RULE4
			rst_q.fifo     <= is_full && !prm[nicd_pkg::B_FIFO]; // RULE5
			rst_q.bus      <= is_full && !prm[nicd_pkg::B_BUS]; // RULE6
			rst_q.dma      <= sr_dma; // RULE7
			rst_q.tx_fifo  <= cmd_go && kind == nicd_pkg::CMD_TXRST && !prm[nicd_pkg::B_FIFO]; // RULE10
			rst_q.tx_logic <= cmd_go && kind == nicd_pkg::CMD_TXRST && !prm[nicd_pkg::B_DMA]; // RULE11
			rst_q.rx_fifo  <= cmd_go && kind == nicd_pkg::CMD_RXRST && !prm[nicd_pkg::B_FIFO]; // RULE12
			rst_q.rx_logic <= cmd_go && kind == nicd_pkg::CMD_RXRST && !prm[nicd_pkg::B_DMA]; // RULE13
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			phy_q     <= 1'b0;
			phy_cnt_q <= 6'h00;
		end
		else if (is_full && !prm[nicd_pkg::B_PHY])
		begin
			phy_q     <= 1'b1; // RULE3
			phy_cnt_q <= nicd_pkg::PHY_SLEEP_CYCLES - 6'h01;
		end
		else if (phy_cnt_q != 6'h00)
			phy_cnt_q <= phy_cnt_q - 6'h01;
		else
			phy_q <= 1'b0;
	end

	// ==========================================================
	// Engine controls
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			tx_on_q   <= 1'b0;
			tx_hold_q <= 1'b0;
			rx_hold_q <= 1'b0;
			drop_q    <= 1'b0;
		end
		else
		begin
			drop_q <= cmd_go && kind == nicd_pkg::CMD_DROP; // RULE21
			if (sr_dma)
			begin
				tx_on_q   <= 1'b0; // RULE7
				tx_hold_q <= 1'b0;
				rx_hold_q <= 1'b0;
			end
			else
			begin
				if (cmd_go && kind == nicd_pkg::CMD_TXON)
					tx_on_q <= 1'b1; // RULE15
				else if (st_q == nicd_pkg::ST_TXOFF && !TX_PKT_ACTIVE)
					tx_on_q <= 1'b0; // RULE14
				if (cmd_go && kind == nicd_pkg::CMD_TXHOLD)
					tx_hold_q <= 1'b1; // RULE16
				else if (cmd_go && kind == nicd_pkg::CMD_TXREL)
					tx_hold_q <= 1'b0; // RULE18
				if (cmd_go && kind == nicd_pkg::CMD_RXHOLD)
					rx_hold_q <= 1'b1; // RULE24
				else if (cmd_go && (kind == nicd_pkg::CMD_RXREL
					|| (kind == nicd_pkg::CMD_RXRST && !prm[nicd_pkg::B_DMA])))
					rx_hold_q <= 1'b0; // RULE13
			end
		end
	end

	// ==========================================================
	// Start level and hash filter
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			level_q <= nicd_pkg::LEVEL_RST;
		else if (lvl_rst)
			level_q <= nicd_pkg::LEVEL_RST; // RULE10
		else if (cmd_go && kind == nicd_pkg::CMD_LEVEL)
			level_q <= {prm, 2'b00}; // RULE19
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			hash_q <= '0;
		else if (sr_all)
			hash_q <= '0;
		else if (cmd_go && kind == nicd_pkg::CMD_HASH)
			hash_q[prm[nicd_pkg::HIDX_W-1:0]] <= prm[nicd_pkg::B_HSET]; // RULE22
	end

	// ==========================================================
	// Transmit queueing and multicast check
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			queue_q  <= 1'b0;
			mc_acc_q <= 1'b0;
			mc_dis_q <= 1'b0;
		end
		else
		begin
			queue_q  <= tx_on_q && ADAPTER_OPEN && TX_PKT_PRESENT // RULE15
				&& (TX_FIFO_BYTES > BYTES_W'(level_q) || TX_PKT_LOADED); // RULE20
			mc_acc_q <= MC_CHECK && hash_q[MC_CRC]; // RULE23
			mc_dis_q <= MC_CHECK && !hash_q[MC_CRC]; // RULE23
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	logic        arready_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= nicd_pkg::RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end
		else if (ARVALID && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= nicd_pkg::RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			case (ARADDR)
				ADDR_W'(nicd_pkg::ADDR_CMD):  rdata_q <= 32'h0000_0000;
				ADDR_W'(nicd_pkg::ADDR_STAT):
				begin
					rdata_q[nicd_pkg::STAT_BUSY]  <= busy_q; // RULE9
					rdata_q[nicd_pkg::STAT_TXON]  <= tx_on_q;
					rdata_q[nicd_pkg::STAT_TXHLD] <= tx_hold_q;
					rdata_q[nicd_pkg::STAT_RXHLD] <= rx_hold_q;
					rdata_q[nicd_pkg::STAT_PHY]   <= phy_q;
				end
				ADDR_W'(nicd_pkg::ADDR_LEVEL):   rdata_q <= {19'h0, level_q};
				ADDR_W'(nicd_pkg::ADDR_HASH_LO): rdata_q <= hash_q[31:0];
				ADDR_W'(nicd_pkg::ADDR_HASH_HI): rdata_q <= hash_q[63:32];
				default:                         rresp_q <= nicd_pkg::RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && RREADY)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign AWREADY      = awready_q;
	assign WREADY       = wready_q;
	assign BVALID       = bvalid_q;
	assign BRESP        = bresp_q;
	assign ARREADY      = arready_q;
	assign RVALID       = rvalid_q;
	assign RRESP        = rresp_q;
	assign RDATA        = rdata_q;
	assign RST_PULSE    = rst_q;
	assign PHY_SLEEP    = phy_q;
	assign TX_ENGINE_ON = tx_on_q;
	assign TX_LIST_HOLD = tx_hold_q;
	assign RX_LIST_HOLD = rx_hold_q;
	assign DROP_FRAME   = drop_q;
	assign TX_QUEUE     = queue_q;
	assign MC_ACCEPT    = mc_acc_q;
	assign MC_DISCARD   = mc_dis_q;
	assign CMD_BUSY     = busy_q;

	// ==========================================================
	// Checks
	logic [5:0] phy_run_q;

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			phy_run_q <= 6'h00;
		else if (phy_q)
			phy_run_q <= phy_run_q + 6'h01;
		else
			phy_run_q <= 6'h00;
	end

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	code_field_a: assert property (cmd_go && wcmd_q[15:11] == 5'h13 |=> level_q == {$past(wcmd_q[10:0]), 2'b00})
		else $error("code field misdecoded"); // RULE1
	phy_pulse_a: assert property ($fell(phy_q) |-> phy_run_q == 6'h16)
		else $error("phy sleep length wrong"); // RULE3
	mac_mask_a: assert property (is_full |=> RST_PULSE.mac == !$past(prm[2]))
		else $error("mac reset mask wrong"); // RULE4
	fifo_mask_a: assert property (is_full |=> RST_PULSE.fifo == !$past(prm[3]))
		else $error("fifo reset mask wrong"); // RULE5
	bus_mask_a: assert property (is_full |=> RST_PULSE.bus == !$past(prm[5]))
		else $error("bus reset mask wrong"); // RULE6
	dma_mask_a: assert property (is_full && !prm[8] |=> RST_PULSE.dma && !TX_ENGINE_ON && !RX_LIST_HOLD)
		else $error("engine reset missing"); // RULE7
	full_dev_a: assert property (cmd_go && wcmd_q == 16'h0000 |=> RST_PULSE.device ##1 hash_q == '0)
		else $error("device reset missing"); // RULE8
	busy_hold_a: assert property (cmd_go && kind == nicd_pkg::CMD_FULL |=> CMD_BUSY [*8])
		else $error("busy dropped early"); // RULE9
	tx_flush_a: assert property (cmd_go && kind == nicd_pkg::CMD_TXRST && !prm[3]
		|=> RST_PULSE.tx_fifo && level_q == nicd_pkg::LEVEL_RST)
		else $error("transmit fifo reset wrong"); // RULE10
	tx_logic_a: assert property (cmd_go && kind == nicd_pkg::CMD_TXRST |=> RST_PULSE.tx_logic == !$past(prm[8]))
		else $error("transmit logic reset wrong"); // RULE11
	rx_flush_a: assert property (cmd_go && kind == nicd_pkg::CMD_RXRST |=> RST_PULSE.rx_fifo == !$past(prm[3]))
		else $error("receive fifo reset wrong"); // RULE12
	rx_logic_a: assert property (cmd_go && kind == nicd_pkg::CMD_RXRST && !prm[8] |=> RST_PULSE.rx_logic && !RX_LIST_HOLD)
		else $error("receive logic reset wrong"); // RULE13
	tx_off_a: assert property ($fell(TX_ENGINE_ON) && !rst_q.dma |-> !$past(TX_PKT_ACTIVE))
		else $error("engine stopped mid packet"); // RULE14
	tx_queue_a: assert property (TX_QUEUE |-> $past(tx_on_q) && $past(ADAPTER_OPEN))
		else $error("queued while not allowed"); // RULE15
	tx_hold_a: assert property (cmd_go && kind == nicd_pkg::CMD_TXHOLD |=> TX_LIST_HOLD && CMD_BUSY)
		else $error("transmit hold missing"); // RULE16
	tx_rel_a: assert property (cmd_go && kind == nicd_pkg::CMD_TXREL && !sr_dma |=> !TX_LIST_HOLD)
		else $error("transmit release missing"); // RULE18
	drop_pulse_a: assert property (cmd_go && kind == nicd_pkg::CMD_DROP |=> DROP_FRAME && CMD_BUSY)
		else $error("drop not issued"); // RULE21
	hash_write_a: assert property (cmd_go && kind == nicd_pkg::CMD_HASH |=> hash_q[$past(prm[5:0])] == $past(prm[10]))
		else $error("hash entry not written"); // RULE22
	mc_check_a: assert property (MC_CHECK |=> MC_ACCEPT == $past(hash_q[MC_CRC]) && MC_DISCARD != MC_ACCEPT)
		else $error("multicast decision wrong"); // RULE23
	rx_hold_a: assert property (st_q == nicd_pkg::ST_RXLIST && !RX_LIST_IDLE |=> CMD_BUSY && RX_LIST_HOLD)
		else $error("receive hold released early"); // RULE24
	no_cmd_a: assert property (cmd_go && kind == nicd_pkg::CMD_NONE |=> !CMD_BUSY && $stable(level_q) && $stable(hash_q))
		else $error("unknown command acted"); // RULE25

endmodule : nicd_command_decoder

/* hdl/nicd_pkg.sv */
// Constants and types of the network card command decoder.
// Assumes a single 200 MHz clock and AXI4-Lite register access.
package nicd_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CMD     = 8'h00;
	localparam logic [7:0] ADDR_STAT    = 8'h04;
	localparam logic [7:0] ADDR_LEVEL   = 8'h08;
	localparam logic [7:0] ADDR_HASH_LO = 8'h0c;
	localparam logic [7:0] ADDR_HASH_HI = 8'h10;
	// Status register bit positions
	localparam int STAT_BUSY  = 0;
	localparam int STAT_TXON  = 1;
	localparam int STAT_TXHLD = 2;
	localparam int STAT_RXHLD = 3;
	localparam int STAT_PHY   = 4;
	// ==========================================================
	// Command word layout
	localparam int CODE_MSB = 15;
	localparam int CODE_LSB = 11;
	localparam int PARM_W   = 11;
	localparam logic [4:0] C_FULL  = 5'h00;
	localparam logic [4:0] C_RXRST = 5'h05;
	localparam logic [4:0] C_TXRST = 5'h0b;
	localparam logic [4:0] C_LIST  = 5'h06;
	localparam logic [4:0] C_LEVEL = 5'h13;
	localparam logic [4:0] C_TXOFF = 5'h0a;
	localparam logic [4:0] C_TXON  = 5'h09;
	localparam logic [4:0] C_DROP  = 5'h18;
	localparam logic [4:0] C_HASH  = 5'h19;
	// List sub-commands in parameter bits [4:0]
	localparam logic [4:0] L_RXHOLD = 5'h00;
	localparam logic [4:0] L_RXREL  = 5'h01;
	localparam logic [4:0] L_TXHOLD = 5'h02;
	localparam logic [4:0] L_TXREL  = 5'h03;
	// Parameter bit positions
	localparam int B_PHY  = 0;
	localparam int B_MAC  = 2;
	localparam int B_FIFO = 3;
	localparam int B_BUS  = 5;
	localparam int B_DMA  = 8;
	localparam int B_HSET = 10;
	localparam int HIDX_W = 6;
	localparam int LVL_LSB = 2;
	// ==========================================================
	// Reset values and cycle counts
	localparam logic [12:0] LEVEL_RST        = 13'h1ffc;
	localparam logic [5:0]  PHY_SLEEP_CYCLES = 6'h16;
	localparam logic [5:0]  PATH_RST_CYCLES  = 6'h04;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	// ==========================================================
	typedef enum logic [3:0] {
		CMD_NONE, CMD_FULL, CMD_RXRST, CMD_TXRST, CMD_RXHOLD, CMD_RXREL,
		CMD_TXHOLD, CMD_TXREL, CMD_LEVEL, CMD_TXOFF, CMD_TXON, CMD_DROP, CMD_HASH
	} nicd_cmd_t;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_HOLD   = 6'h02,
		ST_TXOFF  = 6'h04,
		ST_TXLIST = 6'h08,
		ST_RXLIST = 6'h10,
		ST_DROP   = 6'h20
	} nicd_state_t;
	typedef struct packed {
		logic device;
		logic mac;
		logic fifo;
		logic bus;
		logic dma;
		logic tx_fifo;
		logic tx_logic;
		logic rx_fifo;
		logic rx_logic;
	} nicd_rst_t;
endpackage : nicd_pkg
